// file: logic/tho_pkg.sv
// constants, types and helpers shared by the trigger holdoff control block
package tho_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 250;     // clk_sys rate
  localparam int unsigned REF_CLK_MHZ = 100;     // holdoff time base
  localparam int unsigned ACC_W       = 9;       // phase accumulator width
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_CLK_MHZ);
  localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(SYS_CLK_MHZ);
  localparam logic [ACC_W-1:0] ACC_RST  = 9'h000;

  // ----------------------------------------------------------------
  // comparators and counter
  // ----------------------------------------------------------------
  localparam int unsigned N_SYNC = 3;            // sync comparators
  localparam int unsigned JW     = 16;           // johnson field width
  localparam int unsigned CW     = 6;            // binary count width
  localparam logic [CW-1:0] CNT_RST = 6'h00;

  // ----------------------------------------------------------------
  // serial string widths and fields
  // ----------------------------------------------------------------
  localparam int unsigned SAMP_W = 28;
  localparam int unsigned TRIG_W = 24;
  localparam int unsigned TB_W   = 24;

  // sampler string
  localparam int unsigned SP_LVL_LSB = 0;        // trigger level magnitude
  localparam int unsigned SP_LVL_MSB = 9;
  localparam int unsigned SP_LVL_SGN = 10;       // 1 = negative
  localparam int unsigned SP_SLOPE   = 11;       // 1 = negative slope
  localparam int unsigned SP_TEN_N   = 12;       // trigger enable, low true
  localparam int unsigned SP_OFS_LSB = 13;       // offset magnitude
  localparam int unsigned SP_OFS_MSB = 22;
  localparam int unsigned SP_OFS_SGN = 23;       // 1 = negative
  localparam int unsigned SP_X2_N    = 24;       // low true stages
  localparam int unsigned SP_X5_N    = 25;
  localparam int unsigned SP_X10_N   = 26;
  localparam int unsigned SP_OPEN    = 27;       // 1 = input path open

  // trigger string
  localparam int unsigned TS_CNT_LSB = 0;        // johnson holdoff count
  localparam int unsigned TS_CNT_MSB = 15;
  localparam int unsigned TS_EVENTS  = 16;       // 1 = events, 0 = time
  localparam int unsigned TS_NEG_LSB = 17;       // per comparator, 1 = neg
  localparam int unsigned TS_DIS_LSB = 20;       // per comparator, 1 = off
  localparam int unsigned TS_INVERT  = 23;       // common invert line

  localparam logic [SAMP_W-1:0] SAMP_RST = 28'h0000000;
  localparam logic [TRIG_W-1:0] TRIG_RST = 24'h000000;
  localparam logic [TB_W-1:0]   TB_RST   = 24'h000000;

  // ----------------------------------------------------------------
  // holdoff sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HO_WAIT,                                     // loaded, awaiting edge
    HO_HOLD,                                     // counting down
    HO_ARMED                                     // fast flip-flop enabled
  } tho_state_t;

  // johnson code to binary: ones count, mirrored once the msb is set
  function automatic logic [CW-1:0] johnson_to_bin(input logic [JW-1:0] j);
    logic [CW-1:0] ones;
    ones = '0;
    for (int i = 0; i < JW; i++) begin
      ones = ones + {{(CW-1){1'b0}}, j[i]};
    end
    if (j[JW-1]) begin
      return CW'(2 * JW) - ones;
    end
    return ones;
  endfunction

endpackage

// file: logic/tho_shift_latch.sv
// serial control string shifter with a holding latch
`timescale 1ns/100ps
module tho_shift_latch #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         shift_stb,        // one bit per transfer
  input  wire logic         serial_data_line, // data bit of the transfer
  input  wire logic         latch_stb,        // copy shifter to latch
  output logic [W-1:0]      latched_reg,      // holding latch
  output logic              loaded_reg        // pulse after each latch
);

  logic [W-1:0] shift_reg;                    // shift stage
  logic [W-1:0] shift_next;
  logic [W-1:0] latched_next;
  logic         loaded_next;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // first bit in lands at bit 0 after a full string
  always_comb begin
    shift_next   = shift_reg;
    latched_next = latched_reg;
    loaded_next  = 1'b0;
    if (shift_stb) begin
      shift_next = {serial_data_line, shift_reg[W-1:1]}; // RULE17
    end
    if (latch_stb) begin
      latched_next = shift_reg;                          // RULE18
      loaded_next  = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_reg   <= '0;
      latched_reg <= '0;
      loaded_reg  <= 1'b0;
    end else begin
      shift_reg   <= shift_next;
      latched_reg <= latched_next;
      loaded_reg  <= loaded_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // both checks run on clk_sys and sleep through reset
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_shift_one_bit: assert property ( // RULE17
    shift_stb |=> shift_reg[W-1] == $past(serial_data_line))
    else $error("shifter did not take the serial bit");

  a_latch_copy: assert property ( // RULE18
    latch_stb |=> latched_reg == $past(shift_reg) && loaded_reg)
    else $error("latch did not copy the shifted string");

endmodule // tho_shift_latch

// file: logic/tho_holdoff_top.sv
// trigger holdoff sequencer, sync comparator gating and string latches
`timescale 1ns/100ps

// How it works
// RULE1: time mode counts 100 MHz reference ticks
// RULE2: events mode counts real trigger clocks
// RULE3: first edge enters holdoff, terminal count arms
// RULE4: first trigger after terminal count is accepted
// RULE5: accepted trigger reloads the holdoff counter
// RULE6: status bit shows the holdoff counter state
// RULE7: host ignores first count-down after loading
// RULE8: disabling all comparators isolates external triggers
// RULE9: polarity, invert or level swing make triggers
// RULE10: host sets idle comparator polarity negative
// RULE11: comparator clocks are ORed, resting low
// RULE12: fast trigger responds to rising edges only
// RULE13: four attenuator bits: x10, x5, x2, open
// RULE14: all stages off plus open means grounded
// RULE15: sampler string is bit mapped sign magnitude
// RULE16: counts arrive as johnson code
// RULE17: strings shift one bit per transfer
// RULE18: sampler and trigger latch on strobe
// RULE19: timebase latches on run/stop toggle
// RULE20: load value and mode from trigger string
module tho_holdoff_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [2:0]  sync_cmp_in,     // comparator outputs, async
  input  wire logic        serial_data_line,
  input  wire logic        samp_shift_stb,  // sampler string transfer
  input  wire logic        trig_shift_stb,  // trigger string transfer
  input  wire logic        tb_shift_stb,    // timebase string transfer
  input  wire logic        samp_wr_stb,     // write pulse to sampler
  input  wire logic        samp_rd_stb,     // read pulse to sampler
  input  wire logic        trig_wr_stb,     // write pulse to trigger
  input  wire logic        trig_rd_stb,     // read pulse to trigger
  input  wire logic        run_stop,        // parallel run/stop level
  output logic             holdoff_status,  // high while holding off
  output logic             trig_armed,      // fast flip-flop enabled
  output logic             trig_event,      // one pulse per trigger
  output logic             trig_clk_any,    // ORed comparator clocks
  output logic [9:0]       samp_lvl_mag,
  output logic             samp_lvl_neg,
  output logic             samp_slope_neg,
  output logic             samp_trig_en_n,
  output logic [9:0]       samp_ofs_mag,
  output logic             samp_ofs_neg,
  output logic             att_x10_n,
  output logic             att_x5_n,
  output logic             att_x2_n,
  output logic             att_path_open,
  output logic             att_grounded,    // attenuator output at ground
  output logic [23:0]      tb_ctrl          // latched timebase string
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [tho_pkg::SAMP_W-1:0] samp_str;      // latched sampler string
  logic [tho_pkg::TRIG_W-1:0] trig_str;      // latched trigger string
  logic [tho_pkg::TB_W-1:0]   tb_str;        // latched timebase string
  logic                       trig_loaded;   // pulse after trigger latch
  logic                       run_stop_d_reg;
  logic                       run_stop_d_next;
  logic                       tb_latch;      // run/stop toggled

  logic [tho_pkg::ACC_W-1:0]  acc_reg;       // reference phase
  logic [tho_pkg::ACC_W-1:0]  acc_next;
  logic                       ref_tick_reg;  // 100 MHz enable pulse
  logic                       ref_tick_next;

  logic [2:0] sync1_reg;                     // first synchroniser stage
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;                      // agreed comparator levels
  logic [2:0] filt_next;
  logic [2:0] tclk_reg;                      // gated per comparator
  logic [2:0] tclk_next;
  logic       comb_reg;                      // ORed trigger clock
  logic       comb_next;
  logic       comb_d_reg;                    // previous ORed level
  logic       comb_rise;                     // rising edge only

  tho_pkg::tho_state_t       state_reg;
  tho_pkg::tho_state_t       state_next;
  logic [tho_pkg::CW-1:0]    cnt_reg;        // holdoff down-counter
  logic [tho_pkg::CW-1:0]    cnt_next;
  logic [tho_pkg::CW-1:0]    load_val;       // decoded johnson count
  logic                      events_mode;
  logic                      count_edge;     // edge the counter sees
  logic                      status_next;
  logic                      armed_next;
  logic                      event_next;
  logic                      ground_next;

  // ----------------------------------------------------------------
  // serial string latches
  // ----------------------------------------------------------------
  // sampler and trigger latch on either strobe direction
  tho_shift_latch #(.W(tho_pkg::SAMP_W)) u_samp (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .shift_stb        (samp_shift_stb),
    .serial_data_line (serial_data_line),
    .latch_stb        (samp_wr_stb | samp_rd_stb), // RULE18
    .latched_reg      (samp_str),
    .loaded_reg       ()
  );

  tho_shift_latch #(.W(tho_pkg::TRIG_W)) u_trig (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .shift_stb        (trig_shift_stb),
    .serial_data_line (serial_data_line),
    .latch_stb        (trig_wr_stb | trig_rd_stb), // RULE18
    .latched_reg      (trig_str),
    .loaded_reg       (trig_loaded)
  );

  // timebase has no strobe: a run/stop change latches it
  assign tb_latch = run_stop ^ run_stop_d_reg;     // RULE19

  tho_shift_latch #(.W(tho_pkg::TB_W)) u_tb (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .shift_stb        (tb_shift_stb),
    .serial_data_line (serial_data_line),
    .latch_stb        (tb_latch),
    .latched_reg      (tb_str),
    .loaded_reg       ()
  );

  // run/stop comes from host logic on this clock, no synchroniser
  always_comb begin
    run_stop_d_next = run_stop;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_stop_d_reg <= 1'b0;
    end else begin
      run_stop_d_reg <= run_stop_d_next;
    end
  end

  // ----------------------------------------------------------------
  // reference tick divider
  // ----------------------------------------------------------------
  // 250 to 100 is not integer: phase accumulator, two ticks in five
  always_comb begin
    acc_next      = acc_reg + tho_pkg::ACC_STEP;
    ref_tick_next = 1'b0;
    if (acc_next >= tho_pkg::ACC_MOD) begin
      acc_next      = acc_next - tho_pkg::ACC_MOD;
      ref_tick_next = 1'b1;                        // RULE1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_reg      <= tho_pkg::ACC_RST;
      ref_tick_reg <= 1'b0;
    end else begin
      acc_reg      <= acc_next;
      ref_tick_reg <= ref_tick_next;
    end
  end

  // ----------------------------------------------------------------
  // comparator inputs and trigger clock
  // ----------------------------------------------------------------
  // level changes count only once stages two and three agree
  always_comb begin
    filt_next = (sync2_reg & sync3_reg) |
                (filt_reg & (sync2_reg ^ sync3_reg));
    // negative polarity on an idle low input rests low
    tclk_next = ~trig_str[tho_pkg::TS_DIS_LSB +: 3] &         // RULE8
                (filt_reg ^ ~trig_str[tho_pkg::TS_NEG_LSB +: 3] ^
                 {3{trig_str[tho_pkg::TS_INVERT]}});          // RULE9
    comb_next = |tclk_reg;                                    // RULE11
  end

  // synchroniser, filter and OR tree registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg  <= 3'h0;
      sync2_reg  <= 3'h0;
      sync3_reg  <= 3'h0;
      filt_reg   <= 3'h0;
      tclk_reg   <= 3'h0;
      comb_reg   <= 1'b0;
      comb_d_reg <= 1'b0;
    end else begin
      sync1_reg  <= sync_cmp_in;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      filt_reg   <= filt_next;
      tclk_reg   <= tclk_next;
      comb_reg   <= comb_next;
      comb_d_reg <= comb_reg;
    end
  end

  // falling edges of the ORed clock never reach the sequencer
  assign comb_rise = comb_reg & ~comb_d_reg;                  // RULE12

  // ----------------------------------------------------------------
  // holdoff sequencer
  // ----------------------------------------------------------------
  assign events_mode = trig_str[tho_pkg::TS_EVENTS];          // RULE20
  assign load_val    = tho_pkg::johnson_to_bin(
                         trig_str[tho_pkg::TS_CNT_MSB:
                                  tho_pkg::TS_CNT_LSB]);      // RULE16
  // source of counted edges picked by the mode bit
  assign count_edge  = events_mode ? comb_rise :              // RULE2
                                     ref_tick_reg;            // RULE1

  // a fresh trigger string restarts the cycle with its new count;
  // the first count-down after this is not trusted by software
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    event_next = 1'b0;
    if (trig_loaded) begin
      state_next = tho_pkg::HO_WAIT;
      cnt_next   = load_val;                                  // RULE20
    end else begin
      unique case (state_reg)
        tho_pkg::HO_WAIT: begin
          // first counted edge starts holdoff
          if (count_edge) begin
            state_next = tho_pkg::HO_HOLD;                    // RULE3
          end
        end
        tho_pkg::HO_HOLD: begin
          if (cnt_reg == tho_pkg::CNT_RST) begin
            state_next = tho_pkg::HO_ARMED;                   // RULE3
          end else if (count_edge) begin
            cnt_next = cnt_reg - 6'h01;                       // RULE3
          end
        end
        tho_pkg::HO_ARMED: begin
          // accepted trigger fires and reloads in one step
          if (comb_rise) begin
            event_next = 1'b1;                                // RULE4
            state_next = tho_pkg::HO_WAIT;                    // RULE5
            cnt_next   = load_val;                            // RULE5
          end
        end
      endcase
    end
    status_next = (state_next == tho_pkg::HO_HOLD);           // RULE6
    armed_next  = (state_next == tho_pkg::HO_ARMED);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg      <= tho_pkg::HO_WAIT;
      cnt_reg        <= tho_pkg::CNT_RST;
      holdoff_status <= 1'b0;
      trig_armed     <= 1'b0;
      trig_event     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      holdoff_status <= status_next;
      trig_armed     <= armed_next;
      trig_event     <= event_next;
    end
  end

  // ----------------------------------------------------------------
  // sampler fields
  // ----------------------------------------------------------------
  // bit mapped, magnitude and sign kept apart as the string holds them
  assign samp_lvl_mag   = samp_str[tho_pkg::SP_LVL_MSB:
                                   tho_pkg::SP_LVL_LSB];      // RULE15
  assign samp_lvl_neg   = samp_str[tho_pkg::SP_LVL_SGN];      // RULE15
  assign samp_slope_neg = samp_str[tho_pkg::SP_SLOPE];
  assign samp_trig_en_n = samp_str[tho_pkg::SP_TEN_N];
  assign samp_ofs_mag   = samp_str[tho_pkg::SP_OFS_MSB:
                                   tho_pkg::SP_OFS_LSB];      // RULE15
  assign samp_ofs_neg   = samp_str[tho_pkg::SP_OFS_SGN];      // RULE15
  assign att_x10_n      = samp_str[tho_pkg::SP_X10_N];        // RULE13
  assign att_x5_n       = samp_str[tho_pkg::SP_X5_N];         // RULE13
  assign att_x2_n       = samp_str[tho_pkg::SP_X2_N];         // RULE13
  assign att_path_open  = samp_str[tho_pkg::SP_OPEN];         // RULE13
  assign tb_ctrl        = tb_str;
  assign trig_clk_any   = comb_reg;

  // stages are low true: all high plus open path leaves only ground
  always_comb begin
    ground_next = samp_str[tho_pkg::SP_X10_N] &
                  samp_str[tho_pkg::SP_X5_N] &
                  samp_str[tho_pkg::SP_X2_N] &
                  samp_str[tho_pkg::SP_OPEN];                 // RULE14
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      att_grounded <= 1'b0;
    end else begin
      att_grounded <= ground_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // every check below runs on clk_sys and sleeps through reset
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_armed_hit;
    state_reg == tho_pkg::HO_ARMED && comb_rise && !trig_loaded;
  endsequence

  sequence s_reloaded;
    state_reg == tho_pkg::HO_WAIT && cnt_reg == $past(load_val);
  endsequence

  a_time_tick_count: assert property ( // RULE1
    state_reg == tho_pkg::HO_HOLD && !events_mode && ref_tick_reg &&
    cnt_reg != 6'h00 && !trig_loaded
    |=> cnt_reg == $past(cnt_reg) - 6'h01)
    else $error("time holdoff missed a reference tick");
  a_event_count: assert property ( // RULE2
    state_reg == tho_pkg::HO_HOLD && events_mode && !trig_loaded &&
    cnt_reg != 6'h00
    |=> cnt_reg == $past(cnt_reg) - {5'h00, $past(comb_rise)})
    else $error("events holdoff count mismatch");
  a_first_edge_hold: assert property ( // RULE3
    state_reg == tho_pkg::HO_WAIT && count_edge && !trig_loaded
    |=> holdoff_status)
    else $error("first counted edge did not start holdoff");
  a_arm_at_tc: assert property ( // RULE3
    state_reg == tho_pkg::HO_HOLD && cnt_reg == 6'h00 && !trig_loaded
    |=> trig_armed && !holdoff_status)
    else $error("terminal count did not arm the fast trigger");
  a_trig_accept: assert property ( // RULE4
    s_armed_hit |=> trig_event ##1 !trig_event)
    else $error("armed trigger not taken as one pulse");
  a_trig_reload: assert property ( // RULE5
    s_armed_hit |=> s_reloaded)
    else $error("accepted trigger did not reload the counter");
  a_status_state: assert property ( // RULE6
    holdoff_status == (state_reg == tho_pkg::HO_HOLD))
    else $error("holdoff status disagrees with the counter state");
  a_isolate_all: assert property ( // RULE8
    (&trig_str[tho_pkg::TS_DIS_LSB +: 3]) [*2] |=> !comb_reg)
    else $error("disabled comparators still clock the trigger");
  a_or_rest_low: assert property ( // RULE11
    comb_reg == $past(|tclk_reg))
    else $error("trigger clock is not the OR of the comparators");
  a_rise_only: assert property ( // RULE12
    trig_event |-> $past(comb_reg) && !$past(comb_d_reg))
    else $error("trigger event without a rising clock edge");
  a_ground_flag: assert property ( // RULE14
    att_grounded == $past(att_x10_n & att_x5_n & att_x2_n &
                          att_path_open))
    else $error("grounded flag wrong for attenuator setting");
  a_tb_on_toggle: assert property ( // RULE19
    !$changed(run_stop) |=> $stable(tb_ctrl))
    else $error("timebase string changed without run/stop toggle");

endmodule // tho_holdoff_top

// file: bench/tho_host_model.sv
// host model that shifts and latches serial control strings
`timescale 1ns/100ps
module tho_host_model (
  input  wire logic       clk_sys,
  output logic            serial_data_line,
  output logic [2:0]      shift_stb,  // sampler, trigger, timebase
  output logic [1:0]      samp_lat,   // write, read
  output logic [1:0]      trig_lat,   // write, read
  output logic            run_stop
);
  initial begin
    serial_data_line = 1'b0;
    shift_stb = 3'h0;
    samp_lat = 2'h0;
    trig_lat = 2'h0;
    run_stop = 1'b0;
  end
  // k picks the string, rd picks the read strobe instead of write
  task automatic send(input int k, input logic [27:0] v, input int n,
                      input bit rd);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) #1;
      serial_data_line = v[i];
      shift_stb[k] = 1'b1;
    end
    @(posedge clk_sys) #1;
    shift_stb = 3'h0;
    // released line shows the inverse, never the last bit
    serial_data_line = ~serial_data_line;
    if (k == 0) samp_lat[rd] = 1'b1;
    else if (k == 1) trig_lat[rd] = 1'b1;
    else run_stop = ~run_stop;
    @(posedge clk_sys) #1;
    samp_lat = 2'h0;
    trig_lat = 2'h0;
  endtask
endmodule // tho_host_model

// file: bench/trigger_holdoff_control_tb_top.sv
// self-checking bench for the trigger holdoff control block
`timescale 1ns/100ps
module trigger_holdoff_control_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  sync_cmp_in = 3'h0;
  logic        sdl, run_stop, hold, armed, evt, tclk;
  logic [2:0]  sstb;
  logic [1:0]  slat, tlat;
  logic [9:0]  lvl, ofs;
  logic        lneg, slope, ten_n, oneg, x10, x5, x2, opn, gnd;
  logic [23:0] tb_ctrl;
  logic        f_clk, f_evt, f_arm, f_hold; // seen during a window
  logic [31:0] seed = 32'h00003788;         // 14216
  logic [27:0] v;
  int          err_total = 0;
  int          compares = 0;
  always #2 clk_sys = ~clk_sys;
  tho_host_model host (.clk_sys(clk_sys), .serial_data_line(sdl),
    .shift_stb(sstb), .samp_lat(slat), .trig_lat(tlat),
    .run_stop(run_stop));
  tho_holdoff_top DUT (.clk_sys(clk_sys), .rst(rst),
    .sync_cmp_in(sync_cmp_in), .serial_data_line(sdl),
    .samp_shift_stb(sstb[0]), .trig_shift_stb(sstb[1]),
    .tb_shift_stb(sstb[2]), .samp_wr_stb(slat[0]),
    .samp_rd_stb(slat[1]), .trig_wr_stb(tlat[0]),
    .trig_rd_stb(tlat[1]), .run_stop(run_stop),
    .holdoff_status(hold), .trig_armed(armed), .trig_event(evt),
    .trig_clk_any(tclk), .samp_lvl_mag(lvl), .samp_lvl_neg(lneg),
    .samp_slope_neg(slope), .samp_trig_en_n(ten_n),
    .samp_ofs_mag(ofs), .samp_ofs_neg(oneg), .att_x10_n(x10),
    .att_x5_n(x5), .att_x2_n(x2), .att_path_open(opn),
    .att_grounded(gnd), .tb_ctrl(tb_ctrl));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [27:0] e,
                     input logic [27:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // pulse comparators in m for 8 cycles, then 8 idle cycles, watching all 16
  task automatic tick(input logic [2:0] m);
    {f_clk, f_evt, f_arm, f_hold} = 4'h0;
    for (int j = 0; j < 16; j++) begin
      @(posedge clk_sys) #1;
      sync_cmp_in = (j < 8) ? m : 3'h0;
      f_clk = f_clk | tclk;
      f_evt = f_evt | evt;
      f_arm = f_arm | armed;
      f_hold = f_hold | hold;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys) #1;
    rst = 1'b0;
    // random sampler strings, last one with all stages off, path open
    for (int t = 0; t < 5; t++) begin
      v = 28'((t == 4) ? (rnd() | 32'h0F000000) : rnd());
      host.send(0, v, 28, t[0]);
      @(posedge clk_sys) #1;
      chk("samp", v, {opn, x10, x5, x2, oneg, ofs, ten_n, slope,
                      lneg, lvl});
      chk("gnd", {27'h0, &v[27:24]}, {27'h0, gnd});
    end
    for (int t = 0; t < 2; t++) begin
      v = 28'(rnd() & 32'h00FFFFFF);
      host.send(2, v, 24, 0);
      chk("tb", v, {4'h0, tb_ctrl});
    end
    $display("strings done");
    // time mode, johnson count 3; idle comparators set negative
    host.send(1, 28'h00E0007, 24, 0);
    tick(3'h0);
    chk("time_hold", 28'h1, {27'h0, f_hold});
    chk("time_arm", 28'h1, {27'h0, armed});
    tick(3'h2);
    chk("time_evt", 28'h1, {27'h0, f_evt});
    $display("time holdoff done");
    // events mode, johnson count 1
    host.send(1, 28'h00F0001, 24, 1);
    tick(3'h1);
    chk("ev_hold", 28'h1, {27'h0, f_hold & ~f_arm});
    tick(3'h1);
    chk("ev_arm", 28'h1, {27'h0, f_arm & ~f_evt});
    tick(3'h1);
    chk("ev_evt", 28'h1, {27'h0, f_evt & f_clk});
    tick(3'h1);
    chk("ev_reload", 28'h1, {27'h0, f_hold});
    $display("events holdoff done");
    // all comparators disabled
    host.send(1, 28'h07F0001, 24, 0);
    tick(3'h7);
    chk("iso", 28'h0, {26'h0, f_clk, f_hold});
    // invert line alone makes a trigger clock edge
    host.send(1, 28'h08F0001, 24, 0);
    tick(3'h0);
    chk("inv", 28'h1, {27'h0, f_hold});
    $display("isolation and invert done");
    wrap_up();
  end
endmodule // trigger_holdoff_control_tb_top
